// ==== common/csc_pkg.sv ====
// Constants and helpers shared by the clock synthesizer control block.
// Assumes a 100 MHz system clock; the internal CPU clock runs at half of it.
package csc_pkg;

  // Serial interface framing
  localparam int         BYTE_W    = 8;
  localparam logic [7:0] WR_ADDR   = 8'hD2;
  localparam logic [7:0] RD_ADDR   = 8'hD3;
  localparam int         CFG_BYTES = 6;
  localparam logic [7:0] RD_COUNT  = 8'h06;
  // Answer for reads past the last configuration byte
  localparam logic [7:0] RD_FILL   = 8'hFF;

  // Configuration reset image, byte i at bits [8*i +: 8]
  localparam logic [CFG_BYTES*8-1:0] CFG_RESET = 48'h0000_0000_0000;

  // Dual-function pins
  localparam int STRAP_W = 5;
  localparam int PIN_REF = 0;
  localparam int PIN_USB = 1;

  // Clock and timing
  localparam int CLK_NS          = 10;
  localparam int PWRUP_MAX_MS    = 3;
  localparam int PWRUP_MAX_CYC   = PWRUP_MAX_MS * 1_000_000 / CLK_NS;
  localparam int POR_NS          = 2000;
  localparam int POR_CYC         = (POR_NS + CLK_NS - 1) / CLK_NS;
  localparam int OSC_SETTLE_NS   = 5000;
  localparam int OSC_SETTLE_CYC  = (OSC_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CPU_LAT_MAX_CLK = 4;
  localparam int CPU_MIN_ON_CLK  = 100;

  // Peripheral clock model: taps of a free divider
  localparam int DIV_W   = 4;
  localparam int REF_BIT = 3;
  localparam int USB_BIT = 1;
  localparam int PCI_BIT = 2;

  // Gate enable that only changes while the gated clock is low
  function automatic logic gate_en(input logic en,
                                   input logic nxt,
                                   input logic want);
    return want ? (en | ~nxt) : (en & nxt);
  endfunction

endpackage

// ==== test/csc_checker.sv ====
// Pin-level assertions for the clock synthesizer control block.
// Bound to csc_top; sees only that module's ports.
`timescale 1ns/1ns
module csc_checker
#(
  parameter int PWRUP_MAX  = 2000,
  parameter int OSC_SETTLE = 20,
  parameter int POR_LEN    = 10
)
(
  input wire logic                            clock,
  input wire logic                            arst_n,
  input wire logic                            scl_i,
  input wire logic                            sda_i,
  input wire logic                            sda_o,
  input wire logic                            sda_oe,
  input wire logic                            power_down_n,
  input wire logic                            cpu_stop_n,
  input wire logic [csc_pkg::STRAP_W-1:0]     strap_pin_i,
  input wire logic [csc_pkg::STRAP_W-1:0]     strap_pin_o,
  input wire logic [csc_pkg::STRAP_W-1:0]     strap_pin_oe,
  input wire logic [csc_pkg::STRAP_W-1:0]     strap_q,
  input wire logic [csc_pkg::CFG_BYTES*8-1:0] cfg_out,
  input wire logic                            osc_en,
  input wire logic                            cpu_clk_out,
  input wire logic                            cpu_diff_true_out,
  input wire logic                            cpu_diff_comp_out
);
  import csc_pkg::*;
  // Settle plus worst park of the reference divider
  localparam int WAKE_MAX = OSC_SETTLE + 40;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_cpu_held_off;
    (!cpu_stop_n && power_down_n)[*8];
  endsequence
  sequence s_ref_full_high;
    strap_pin_o[PIN_REF][*7] ##1 !strap_pin_o[PIN_REF];
  endsequence
  chk_cpu_off_lat:
    assert property (s_cpu_held_off |-> !cpu_clk_out)
    else $error("cpu clock runs after stop");
  chk_cpu_on_lat:
    assert property ($rose(cpu_stop_n) && power_down_n && osc_en
      |-> ##[1:8] cpu_clk_out)
    else $error("cpu clock late to restart");
  chk_cpu_stop_low:
    assert property (cpu_clk_out |=> !cpu_clk_out)
    else $error("cpu clock held high");
  chk_park_low:
    assert property (!osc_en |-> strap_pin_o == '0 && !cpu_clk_out)
    else $error("oscillator off with output high");
  chk_park_bound:
    assert property ($fell(power_down_n) |-> ##[1:40] !osc_en)
    else $error("power down too slow");
  chk_wake_bound:
    assert property ($rose(osc_en) |-> ##[1:WAKE_MAX] strap_pin_o[PIN_REF])
    else $error("clocks not back after wake");
  chk_ref_steady:
    assert property ($rose(strap_pin_o[PIN_REF]) &&
      $past(strap_pin_oe[PIN_REF]) |=> s_ref_full_high)
    else $error("reference high phase disturbed");
  chk_strap_keep:
    assert property (strap_pin_oe[0] |->
      strap_pin_oe == 5'h1F && $stable(strap_q))
    else $error("strap latch or drive changed");
  chk_sda_open:
    assert property (sda_o == 1'b0)
    else $error("data line driven high");
  chk_sda_on_low:
    assert property ($changed(sda_oe) |-> !$past(scl_i, 2))
    else $error("data line moved while clock high");
endmodule // csc_checker

// ==== test/csc_host_model.sv ====
// Serial bus host model for the clock synthesizer bench.
// Open drain: pull_low high pulls data low; bench adds the pull-up.
`timescale 1ns/1ns
module csc_host_model
(
  output logic      scl,
  output logic      pull_low,
  input  wire logic sda
);
  initial
  begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  // 8 MHz instead of the bus limit, to keep runs short
  task automatic bit_io(input logic b, output logic r);
    #31 pull_low = ~b;
    #31 scl = 1'b1;
    #31 r = sda;
    #32 scl = 1'b0;
  endtask
  // Also serves as repeated start
  task automatic start_cond();
    #31 pull_low = 1'b0;
    #31 scl = 1'b1;
    #62 pull_low = 1'b1;
    #62 scl = 1'b0;
  endtask
  task automatic stop_cond();
    #31 pull_low = 1'b1;
    #31 scl = 1'b1;
    #62 pull_low = 1'b0;
    #62;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv_byte(output logic [7:0] b, input logic more);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(~more, r);
  endtask
endmodule // csc_host_model

// ==== test/tb_top.sv ====
// Self-checking bench for the clock synthesizer control block.
// Host model drives the serial pins; bench drives power pins, straps.
`timescale 1ns/1ns
module tb_top;
  import csc_pkg::*;
  localparam int POR_T    = 10;
  localparam int SETTLE_T = 20;
  logic clock, arst_n, power_down_n, cpu_stop_n, scl, host_pull, sda_w;
  logic sda_o, sda_oe, osc_en, cpu_clk_out, diff_t, diff_c, ack;
  logic [STRAP_W-1:0]     strap_in, strap_o, strap_oe, strap_q, strap_lvl;
  logic [CFG_BYTES*8-1:0] cfg_out, cfg_exp;
  logic [7:0]             rd;
  int errors, checks_done, hi_ref, hi_cpu, hi_diff;
  assign sda_w = ~((sda_oe & ~sda_o) | host_pull);
  assign strap_in = (strap_oe & strap_o) | (~strap_oe & strap_lvl);
  csc_top #(.PWRUP_MAX(2000), .OSC_SETTLE(SETTLE_T), .POR_LEN(POR_T)) dut_u (
    .clock(clock), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .power_down_n(power_down_n),
    .cpu_stop_n(cpu_stop_n), .strap_pin_i(strap_in), .strap_pin_o(strap_o),
    .strap_pin_oe(strap_oe), .strap_q(strap_q), .cfg_out(cfg_out),
    .osc_en(osc_en), .cpu_clk_out(cpu_clk_out),
    .cpu_diff_true_out(diff_t), .cpu_diff_comp_out(diff_c));
  csc_host_model host_u (.scl(scl), .pull_low(host_pull), .sda(sda_w));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string what, input logic [47:0] exp,
                     input logic [47:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic watch(input int n);
    hi_ref = 0;
    hi_cpu = 0;
    hi_diff = 0;
    repeat (n)
    begin
      @(posedge clock);
      hi_ref += int'(strap_o[PIN_REF] === 1'b1);
      hi_cpu += int'(cpu_clk_out === 1'b1);
      hi_diff += int'(diff_t === 1'b1 && diff_c === 1'b0);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_por();
    chk("cfg at reset", CFG_RESET, cfg_out);
    // Ref gate opens only at its first low after power-on
    repeat (POR_T + 8) @(posedge clock);
    chk("strap latch", 48'(strap_lvl), 48'(strap_q));
    chk("strap drive", 48'h1F, 48'(strap_oe));
    watch(32);
    chk("ref on pin", 16, 48'(hi_ref));
    $display("t_por done");
  endtask
  task automatic t_write();
    logic r;
    host_u.start_cond();
    host_u.send_byte(WR_ADDR, ack);
    chk("ack addr", 1, 48'(ack));
    host_u.send_byte(8'h5A, ack);
    chk("ack cmd", 1, 48'(ack));
    host_u.send_byte(8'h07, ack);
    chk("ack count", 1, 48'(ack));
    // Seventh byte lies past the table and must be dropped
    for (int i = 0; i < 7; i++)
    begin
      host_u.send_byte(8'(8'h11 * (i + 1)), ack);
      chk("ack data", 1, 48'(ack));
    end
    host_u.stop_cond();
    repeat (4) @(posedge clock);
    cfg_exp = 48'h6655_4433_2211;
    chk("cfg written", cfg_exp, cfg_out);
    host_u.start_cond();
    host_u.send_byte(WR_ADDR, ack);
    host_u.send_byte(8'h00, ack);
    host_u.send_byte(8'h01, ack);
    host_u.send_byte(8'hA5, ack);
    repeat (4) host_u.bit_io(1'b0, r);
    host_u.stop_cond();
    repeat (4) @(posedge clock);
    cfg_exp[7:0] = 8'hA5;
    chk("cfg after cut", cfg_exp, cfg_out);
    $display("t_write done");
  endtask
  task automatic t_read();
    host_u.start_cond();
    host_u.send_byte(8'hA6, ack);
    chk("ack foreign", 0, 48'(ack));
    host_u.start_cond();
    host_u.send_byte(RD_ADDR, ack);
    chk("ack read", 1, 48'(ack));
    host_u.recv_byte(rd, 1'b1);
    chk("read count", 48'(RD_COUNT), 48'(rd));
    for (int i = 0; i < CFG_BYTES; i++)
    begin
      host_u.recv_byte(rd, i < CFG_BYTES - 1);
      chk("read byte", 48'(cfg_exp[8*i +: 8]), 48'(rd));
    end
    host_u.stop_cond();
    $display("t_read done");
  endtask
  task automatic t_cpu_stop();
    @(posedge clock);
    cpu_stop_n <= 1'b0;
    repeat (8) @(posedge clock);
    watch(32);
    chk("cpu held", 0, 48'(hi_cpu));
    chk("pair held", 0, 48'(hi_diff));
    chk("ref undisturbed", 16, 48'(hi_ref));
    cpu_stop_n <= 1'b1;
    watch(10);
    chk("cpu restart", 1, 48'(hi_cpu > 0));
    repeat (200) @(posedge clock);
    $display("t_cpu_stop done");
  endtask
  task automatic t_pwr_down();
    @(posedge clock);
    power_down_n <= 1'b0;
    repeat (40) @(posedge clock);
    chk("osc off", 0, 48'(osc_en));
    chk("pins parked", 0, 48'(strap_o));
    watch(16);
    chk("cpu parked", 0, 48'(hi_cpu + hi_ref));
    chk("pair runs", 8, 48'(hi_diff));
    cpu_stop_n <= 1'b0;
    watch(16);
    chk("stop ignored", 8, 48'(hi_diff));
    cpu_stop_n <= 1'b1;
    repeat (8) @(posedge clock);
    power_down_n <= 1'b1;
    repeat (SETTLE_T + 40) @(posedge clock);
    watch(32);
    chk("ref after wake", 16, 48'(hi_ref));
    $display("t_pwr_down done");
  endtask
  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    close_out();
  end
  initial
  begin
    arst_n = 1'b0;
    power_down_n = 1'b1;
    cpu_stop_n = 1'b1;
    strap_lvl = 5'h15;
    errors = 0;
    checks_done = 0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    t_por();
    t_write();
    t_read();
    t_cpu_stop();
    t_pwr_down();
    close_out();
  end
endmodule // tb_top
bind csc_top csc_checker #(.PWRUP_MAX(PWRUP_MAX), .OSC_SETTLE(OSC_SETTLE),
  .POR_LEN(POR_LEN)) chk_u (
  .clock(clock), .arst_n(arst_n), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe), .power_down_n(power_down_n),
  .cpu_stop_n(cpu_stop_n), .strap_pin_i(strap_pin_i),
  .strap_pin_o(strap_pin_o), .strap_pin_oe(strap_pin_oe),
  .strap_q(strap_q), .cfg_out(cfg_out), .osc_en(osc_en),
  .cpu_clk_out(cpu_clk_out), .cpu_diff_true_out(cpu_diff_true_out),
  .cpu_diff_comp_out(cpu_diff_comp_out));

// ==== verilog/csc_cpu_gate.sv ====
// Internal CPU clock phase and glitch-free gating of the CPU outputs.
// Assumes run requests come from synchronised, same-clock logic.
`timescale 1ns/1ns
module csc_cpu_gate
  import csc_pkg::*;
(
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic run_single,
  input  wire logic run_diff,
  output      logic ph_fall,
  output      logic single_on,
  output      logic cpu_clk_out,
  output      logic cpu_diff_true_out,
  output      logic cpu_diff_comp_out
);

  logic ph_q, ph_d;
  logic en_s_q, en_s_d;
  logic en_t_q, en_t_d;
  logic fall_d, out_s_d, true_d;

  always_comb
  begin
    ph_d    = ~ph_q;
    fall_d  = ph_q;
    // Enables move only when the next phase is low: no runt highs
    en_s_d  = gate_en(en_s_q, ph_d, run_single);
    en_t_d  = gate_en(en_t_q, ph_d, run_diff);
    out_s_d = en_s_d & ph_d;
    true_d  = en_t_d & ph_d;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ph_q              <= 1'b0;
      en_s_q            <= 1'b0;
      en_t_q            <= 1'b0;
      ph_fall           <= 1'b0;
      cpu_clk_out       <= 1'b0;
      cpu_diff_true_out <= 1'b0;
      cpu_diff_comp_out <= 1'b1;
    end
    else
    begin
      ph_q              <= ph_d;
      en_s_q            <= en_s_d;
      en_t_q            <= en_t_d;
      ph_fall           <= fall_d;
      cpu_clk_out       <= out_s_d;
      cpu_diff_true_out <= true_d;
      cpu_diff_comp_out <= ~true_d;
    end
  end

  assign single_on = en_s_q;

endmodule // csc_cpu_gate

// ==== verilog/csc_sync.sv ====
// Two flip-flop synchroniser for asynchronous pin levels.
// Assumes inputs hold each level for several clock periods.
`timescale 1ns/1ns
module csc_sync
#(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
)
(
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output      logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds the second stage only
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_q <= RST;
      q      <= RST;
    end
    else
    begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // csc_sync

// ==== verilog/csc_top.sv ====
// Control logic of the clock synthesizer: serial slave, strap pins,
// all-clock stop sequence and CPU clock stop.
// Assumes pin inputs are asynchronous and that the serial pins are
// open-drain with external pull-ups.
`timescale 1ns/1ns

// Operation
// - Slave only; host reads configuration back
// - Every serial data unit is eight bits
// - Bytes ascend from zero; stop after any byte
// - Command and count acknowledged, then discarded
// - Data bytes fill successive registers until stop
// - Reset loads every configuration default
// - Power-up latches five strap pin levels
// - After power-on, strap pins drive clocks
// - Synchronise all-clock-stop before powering down
// - Park outputs low before oscillators stop
// - Restart clocks within three milliseconds
// - CPU stop ignored during power-down
// - Reference and 48 MHz stop low early
// - Park starts at first internal CPU fall
// - Stop all but crystal and CPU pair
// - Synchronise CPU stop to internal CPU clock
// - Other clocks run while CPU clocks stopped
// - CPU clocks stop low, restart full high
// - CPU on/off latency below four clocks
// - Writes answer to address byte D2
// - Reads answer to address byte D3
// - Read returns count then bytes zero to five
module csc_top
#(
  parameter int PWRUP_MAX  = csc_pkg::PWRUP_MAX_CYC,
  parameter int OSC_SETTLE = csc_pkg::OSC_SETTLE_CYC,
  parameter int POR_LEN    = csc_pkg::POR_CYC
)
(
  input  wire logic                              clock,
  input  wire logic                              arst_n,
  input  wire logic                              scl_i,
  input  wire logic                              sda_i,
  output      logic                              sda_o,
  output      logic                              sda_oe,
  input  wire logic                              power_down_n,
  input  wire logic                              cpu_stop_n,
  input  wire logic [csc_pkg::STRAP_W-1:0]       strap_pin_i,
  output      logic [csc_pkg::STRAP_W-1:0]       strap_pin_o,
  output      logic [csc_pkg::STRAP_W-1:0]       strap_pin_oe,
  output      logic [csc_pkg::STRAP_W-1:0]       strap_q,
  output      logic [csc_pkg::CFG_BYTES*8-1:0]   cfg_out,
  output      logic                              osc_en,
  output      logic                              cpu_clk_out,
  output      logic                              cpu_diff_true_out,
  output      logic                              cpu_diff_comp_out
);
  import csc_pkg::*;

  localparam int SETTLE = (OSC_SETTLE < PWRUP_MAX) ? OSC_SETTLE
                                                   : PWRUP_MAX - 1;
  localparam int WK_W   = $clog2(SETTLE + 1);
  localparam int POR_W  = $clog2(POR_LEN + 1);
  localparam logic [3:0] BITS   = 4'(BYTE_W);
  localparam logic [3:0] NCFG   = 4'(CFG_BYTES);

  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_ACK, I_RX, I_TX, I_TXACK
  } csc_i2c_e;

  typedef enum logic [1:0] {
    P_RUN, P_PARK, P_OFF, P_WAKE
  } csc_pd_e;

  // Synchronised pins
  logic [3:0]         pin_s;
  logic               scl_s, sda_s, pd_s, cstop_s;
  logic [STRAP_W-1:0] strap_s;

  csc_sync #(.W(4), .RST(4'hF)) u_sync_ctl
  (
    .clock  (clock),
    .arst_n (arst_n),
    .d      ({scl_i, sda_i, power_down_n, cpu_stop_n}),
    .q      (pin_s)
  );

  csc_sync #(.W(STRAP_W), .RST('0)) u_sync_strap
  (
    .clock  (clock),
    .arst_n (arst_n),
    .d      (strap_pin_i),
    .q      (strap_s)
  );

  assign {scl_s, sda_s, pd_s, cstop_s} = pin_s;

  // ---------------- Serial slave ----------------
  csc_i2c_e   st_q, st_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] bit_q, bit_d;
  logic [3:0] cnt_q, cnt_d;
  logic       rw_q, rw_d;
  logic       oe_q, oe_d;
  logic [7:0] cfg_q [CFG_BYTES];
  logic [7:0] cfg_d [CFG_BYTES];
  logic       scl_p_q, sda_p_q;
  logic       scl_rise, scl_fall, start, stop;
  logic [7:0] rd_byte;
  logic [3:0] rd_idx, wr_idx, cnt_inc;

  always_comb
  begin
    scl_rise = scl_s & ~scl_p_q;
    scl_fall = ~scl_s & scl_p_q;
    start    = scl_s & scl_p_q & ~sda_s & sda_p_q;
    stop     = scl_s & scl_p_q & sda_s & ~sda_p_q;
    rd_idx   = cnt_q - 4'd1;
    wr_idx   = cnt_q - 4'd2;
    cnt_inc  = (cnt_q == 4'hF) ? cnt_q : cnt_q + 4'd1;
    // Count byte first, then configuration bytes in order
    if (cnt_q == 4'd0)
      rd_byte = RD_COUNT;
    else if (cnt_q <= NCFG)
      rd_byte = cfg_q[rd_idx[2:0]];
    else
      rd_byte = RD_FILL;
    st_d  = st_q;
    sh_d  = sh_q;
    bit_d = bit_q;
    cnt_d = cnt_q;
    rw_d  = rw_q;
    oe_d  = oe_q;
    cfg_d = cfg_q;
    if (start)
    begin
      st_d  = I_ADDR;
      bit_d = 4'd0;
      cnt_d = 4'd0;
      oe_d  = 1'b0;
    end
    else if (stop)
    begin
      // Bytes commit only when complete, so a cut byte is lost
      st_d = I_IDLE;
      oe_d = 1'b0;
    end
    else
    begin
      unique case (st_q)
        I_IDLE:
          st_d = I_IDLE;
        I_ADDR:
          if (scl_rise)
          begin
            sh_d  = {sh_q[6:0], sda_s};
            bit_d = bit_q + 4'd1;
          end
          else if (scl_fall && bit_q == BITS)
          begin
            bit_d = 4'd0;
            if (sh_q == WR_ADDR || sh_q == RD_ADDR)
            begin
              oe_d = 1'b1;
              rw_d = sh_q[0];
              st_d = I_ACK;
            end
            else
              st_d = I_IDLE;
          end
        I_ACK:
          if (scl_fall)
          begin
            if (rw_q)
            begin
              sh_d  = rd_byte;
              oe_d  = ~rd_byte[7];
              bit_d = 4'd1;
              cnt_d = cnt_inc;
              st_d  = I_TX;
            end
            else
            begin
              oe_d  = 1'b0;
              bit_d = 4'd0;
              st_d  = I_RX;
            end
          end
        I_RX:
          if (scl_rise)
          begin
            sh_d  = {sh_q[6:0], sda_s};
            bit_d = bit_q + 4'd1;
          end
          else if (scl_fall && bit_q == BITS)
          begin
            // Command and count bytes are acknowledged but dropped
            if (cnt_q >= 4'd2 && wr_idx < NCFG)
              cfg_d[wr_idx[2:0]] = sh_q;
            cnt_d = cnt_inc;
            oe_d  = 1'b1;
            bit_d = 4'd0;
            st_d  = I_ACK;
          end
        I_TX:
          if (scl_fall)
          begin
            if (bit_q == BITS)
            begin
              oe_d = 1'b0;
              st_d = I_TXACK;
            end
            else
            begin
              oe_d  = ~sh_q[6];
              sh_d  = {sh_q[6:0], 1'b0};
              bit_d = bit_q + 4'd1;
            end
          end
        I_TXACK:
          if (scl_rise)
            st_d = sda_s ? I_IDLE : I_ACK;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q    <= I_IDLE;
      sh_q    <= 8'h00;
      bit_q   <= 4'h0;
      cnt_q   <= 4'h0;
      rw_q    <= 1'b0;
      oe_q    <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      sda_o   <= 1'b0;
      for (int i = 0; i < CFG_BYTES; i++)
        cfg_q[i] <= CFG_RESET[8*i +: 8];
    end
    else
    begin
      st_q    <= st_d;
      sh_q    <= sh_d;
      bit_q   <= bit_d;
      cnt_q   <= cnt_d;
      rw_q    <= rw_d;
      oe_q    <= oe_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      sda_o   <= 1'b0;
      cfg_q   <= cfg_d;
    end
  end

  assign sda_oe = oe_q;

  always_comb
  begin
    for (int i = 0; i < CFG_BYTES; i++)
      cfg_out[8*i +: 8] = cfg_q[i];
  end

  // ---------------- Power-on and strap pins ----------------
  logic [POR_W-1:0]   por_q, por_d;
  logic               por_done_q, por_done_d;
  logic [STRAP_W-1:0] strap_d;

  always_comb
  begin
    por_d      = por_q;
    por_done_d = por_done_q;
    strap_d    = strap_q;
    if (!por_done_q)
    begin
      if (por_q == POR_W'(POR_LEN - 1))
      begin
        strap_d    = strap_s;
        por_done_d = 1'b1;
      end
      else
        por_d = por_q + POR_W'(1);
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      por_q        <= '0;
      por_done_q   <= 1'b0;
      strap_q      <= '0;
      strap_pin_oe <= '0;
    end
    else
    begin
      por_q        <= por_d;
      por_done_q   <= por_done_d;
      strap_q      <= strap_d;
      // Pins turn to outputs one edge after the latch closes
      strap_pin_oe <= {STRAP_W{por_done_q}};
    end
  end

  // ---------------- Clock stop sequencing ----------------
  csc_pd_e            ps_q, ps_d;
  logic [DIV_W-1:0]   div_q, div_d;
  logic [STRAP_W-1:0] en_q, en_d, nxt, out_d;
  logic [WK_W-1:0]    wk_q, wk_d;
  logic               osc_d, cpu_ok_q, cpu_ok_d, want;
  logic               cpu_fall, cpu_single_on;

  always_comb
  begin
    ps_d  = ps_q;
    wk_d  = wk_q;
    osc_d = osc_en;
    // Dividers halt with the oscillator
    div_d = osc_en ? div_q + DIV_W'(1) : div_q;
    nxt   = {STRAP_W{div_d[PCI_BIT]}};
    nxt[PIN_REF] = div_d[REF_BIT];
    nxt[PIN_USB] = div_d[USB_BIT];
    // CPU stop is frozen outside normal running
    cpu_ok_d = (ps_q == P_RUN) ? cstop_s : cpu_ok_q;
    want = (ps_q == P_RUN) && por_done_q;
    for (int i = 0; i < STRAP_W; i++)
      en_d[i] = gate_en(en_q[i], nxt[i], want);
    out_d = en_d & nxt;
    unique case (ps_q)
      P_RUN:
        if (!pd_s && cpu_fall)
          ps_d = P_PARK;
      P_PARK:
        // Oscillator stays on until every strap output and the single-ended CPU clock sit low
        if (en_q == '0 && !cpu_single_on)
        begin
          ps_d  = P_OFF;
          osc_d = 1'b0;
        end
      P_OFF:
        if (pd_s)
        begin
          ps_d  = P_WAKE;
          osc_d = 1'b1;
          wk_d  = '0;
        end
      P_WAKE:
        if (wk_q == WK_W'(SETTLE))
          ps_d = P_RUN;
        else
          wk_d = wk_q + WK_W'(1);
    endcase
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ps_q        <= P_RUN;
      div_q       <= '0;
      en_q        <= '0;
      wk_q        <= '0;
      osc_en      <= 1'b1;
      cpu_ok_q    <= 1'b1;
      strap_pin_o <= '0;
    end
    else
    begin
      ps_q        <= ps_d;
      div_q       <= div_d;
      en_q        <= en_d;
      wk_q        <= wk_d;
      osc_en      <= osc_d;
      cpu_ok_q    <= cpu_ok_d;
      strap_pin_o <= out_d;
    end
  end

  // Single-ended CPU clock parks with the rest; the pair keeps running
  csc_cpu_gate u_cpu_gate
  (
    .clock             (clock),
    .arst_n            (arst_n),
    .run_single        (cpu_ok_q && ps_q == P_RUN),
    .run_diff          (cpu_ok_q),
    .ph_fall           (cpu_fall),
    .single_on         (cpu_single_on),
    .cpu_clk_out       (cpu_clk_out),
    .cpu_diff_true_out (cpu_diff_true_out),
    .cpu_diff_comp_out (cpu_diff_comp_out)
  );

endmodule // csc_top
